/* core/charge_seq_pkg.sv */
// Purpose: Shared constants and types for the charge sequencer.
// Assumes: 40 MHz ref_clk, APB slave with 12-bit byte addresses.
// Notes: Phase limits are counted in 1 ms ticks.

package charge_seq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS = 1_000_000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int PREQUAL_TIME_MS = 450_000;
  localparam int FAST_TIME_MS = 5_400_000;
  localparam int FULL_TIME_MS = 5_400_000;
  localparam int TOPOFF_TIME_MS = 2_700_000;
  localparam int TIMER_W = 24;
  localparam int PRESCALE_W = 16;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] TIMER_ONE_ADDR = 12'h008;
  localparam logic [11:0] TIMER_TWO_ADDR = 12'h00C;
  localparam int CTRL_HALT_BIT = 0;
  localparam logic CTRL_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET, ST_PREQUAL, ST_FAST, ST_FULL, ST_TOPOFF, ST_DONE, ST_FAULT
  } charge_state_t;

  typedef enum logic [1:0] {
    CUR_ZERO, CUR_TWENTIETH, CUR_LIMIT, CUR_CONST_V
  } drive_t;

  typedef struct packed {
    logic charger_off_input;
    logic bias_ok;
    logic above_uv;
    logic temp_ok;
    logic at_reg_volt;
    logic below_tenth;
    logic below_recharge;
    logic headroom_ok;
    logic over_volt;
  } sense_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage

/* core/charge_sequencer.sv */
// Purpose: Charge sequencing state machine for a Li+ charger.
// Assumes: Sense inputs are comparator pins, asynchronous to ref_clk.
// Notes: Indicator outputs are pull-low enables of open-drain pins.
//
// Overview of operation
// R1: Shutdown or power-up enters reset, timers cleared.
// R2: Reset leads to prequal at twentieth current.
// R3: Prequal advances when above undervoltage, temperature good.
// R4: Prequal timeout below undervoltage gives fault.
// R5: Timer one bounds prequal; timer two fast.
// R6: Prequal bad temperature pauses current and timer.
// R7: Fast charge pulls its indicator, constant current.
// R8: Regulation voltage reached moves fast to full.
// R9: Fast timer expiry stops charging with fault.
// R10: Fast charge bad temperature pauses, freezes timers.
// R11: Full charge pulls its indicator, constant voltage.
// R12: Low current or timer moves full to top-off.
// R13: Top-off charges until its timer, then done.
// R14: Done gives zero current; recharge threshold restarts.
// R15: Full or top-off bad temperature pauses, freezes.
// R16: Reset holds timers cleared, zero current, indicators released.
// R17: Low headroom or overvoltage returns to reset.
// R18: Fault holds until power cycle or shutdown.
// R19: Shutdown held low keeps reset, zero current.

module charge_sequencer
#(
  parameter int TICK_LEN = charge_seq_pkg::TICK_CYCLES,
  parameter int PREQUAL_TICKS = charge_seq_pkg::PREQUAL_TIME_MS,
  parameter int FAST_TICKS = charge_seq_pkg::FAST_TIME_MS,
  parameter int FULL_TICKS = charge_seq_pkg::FULL_TIME_MS,
  parameter int TOPOFF_TICKS = charge_seq_pkg::TOPOFF_TIME_MS
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire charge_seq_pkg::sense_t sense,
  input wire charge_seq_pkg::apb_req_t apb_req,
  output charge_seq_pkg::apb_rsp_t apb_rsp,
  output charge_seq_pkg::drive_t charge_drive,
  output logic fast_pull_low,
  output logic full_pull_low,
  output logic fault_pull_low
);

  import charge_seq_pkg::*;

  localparam logic [TIMER_W-1:0] PREQUAL_LIM = TIMER_W'(PREQUAL_TICKS);
  localparam logic [TIMER_W-1:0] FAST_LIM = TIMER_W'(FAST_TICKS);
  localparam logic [TIMER_W-1:0] FULL_LIM = TIMER_W'(FULL_TICKS);
  localparam logic [TIMER_W-1:0] TOPOFF_LIM = TIMER_W'(TOPOFF_TICKS);
  localparam logic [PRESCALE_W-1:0] TICK_LAST = PRESCALE_W'(TICK_LEN - 1);

  sense_t sense_meta;
  sense_t live;
  logic soft_halt;
  logic halt;
  charge_state_t state;
  charge_state_t next_state;
  logic [PRESCALE_W-1:0] prescale;
  logic tick;
  logic [TIMER_W-1:0] phase_timer_one;
  logic [TIMER_W-1:0] phase_timer_two;
  logic [TIMER_W-1:0] one_limit;
  logic one_expired;
  logic two_expired;
  logic active;
  logic paused;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Comparator outputs change at any time, so both stages are needed
  // before the state machine may look at them.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sense_meta <= '0;
      live <= '0;
    end
    else if (clk_en)
    begin
      sense_meta <= sense;
      live <= sense_meta;
    end
  end

  assign halt = ~live.charger_off_input | soft_halt;
  assign active = (state == ST_PREQUAL) || (state == ST_FAST) ||
                  (state == ST_FULL) || (state == ST_TOPOFF);
  assign paused = active && !live.temp_ok;

  // ----------------------------------------------------------------
  // Phase timers
  // ----------------------------------------------------------------
  // A millisecond prescaler keeps the phase counters narrow; the
  // price is up to one tick of slack on each limit.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      prescale <= '0;
    else if (clk_en)
    begin
      if (prescale == TICK_LAST)
        prescale <= '0;
      else
        prescale <= prescale + PRESCALE_W'(1);
    end
  end

  assign tick = (prescale == TICK_LAST);

  always_comb
  begin
    case (state)
      ST_PREQUAL: one_limit = PREQUAL_LIM; // R5
      ST_FULL: one_limit = FULL_LIM;
      ST_TOPOFF: one_limit = TOPOFF_LIM;
      default: one_limit = PREQUAL_LIM;
    endcase
  end

  assign one_expired = (phase_timer_one >= one_limit);
  assign two_expired = (phase_timer_two >= FAST_LIM); // R5

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      phase_timer_one <= '0;
    else if (clk_en)
    begin
      if (halt || state == ST_RESET || next_state != state)
        phase_timer_one <= '0; // R1 R16
      else if (tick && !paused && !one_expired &&
               (state == ST_PREQUAL || state == ST_FULL ||
                state == ST_TOPOFF))
        phase_timer_one <= phase_timer_one + TIMER_W'(1); // R6 R15
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      phase_timer_two <= '0;
    else if (clk_en)
    begin
      if (halt || state == ST_RESET)
        phase_timer_two <= '0; // R1 R16
      else if (tick && !paused && !two_expired && state == ST_FAST)
        phase_timer_two <= phase_timer_two + TIMER_W'(1); // R10
    end
  end

  // ----------------------------------------------------------------
  // Charge state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RESET:
        if (live.bias_ok)
          next_state = ST_PREQUAL; // R2
      ST_PREQUAL:
        if (live.temp_ok && live.above_uv)
          next_state = ST_FAST; // R3
        else if (one_expired && !live.above_uv)
          next_state = ST_FAULT; // R4
      ST_FAST:
        if (live.temp_ok && live.at_reg_volt)
          next_state = ST_FULL; // R8
        else if (two_expired)
          next_state = ST_FAULT; // R9
      ST_FULL:
        if (live.temp_ok && (live.below_tenth || one_expired))
          next_state = ST_TOPOFF; // R12
      ST_TOPOFF:
        if (live.temp_ok && one_expired)
          next_state = ST_DONE; // R13
      ST_DONE:
        if (live.below_recharge)
          next_state = ST_RESET; // R14
      ST_FAULT:
        next_state = ST_FAULT; // R18
      default:
        next_state = ST_RESET;
    endcase
    if (state != ST_FAULT && (!live.headroom_ok || live.over_volt))
      next_state = ST_RESET; // R17
    if (halt)
      next_state = ST_RESET; // R1 R18 R19
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state <= ST_RESET; // R1
    else if (clk_en)
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Charge command and indicators
  // ----------------------------------------------------------------
  // Outputs follow the next state so that they change on the same
  // edge as the state register. A temperature pause zeroes the
  // current but leaves the indicators as they were.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      charge_drive <= CUR_ZERO;
    else if (clk_en)
    begin
      if (!live.temp_ok)
        charge_drive <= CUR_ZERO; // R6 R10 R15
      else
        case (next_state)
          ST_PREQUAL: charge_drive <= CUR_TWENTIETH; // R2
          ST_FAST: charge_drive <= CUR_LIMIT; // R7
          ST_FULL: charge_drive <= CUR_CONST_V; // R11
          ST_TOPOFF: charge_drive <= CUR_CONST_V; // R13
          default: charge_drive <= CUR_ZERO; // R14 R16 R19
        endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fast_pull_low <= 1'h0;
      full_pull_low <= 1'h0;
      fault_pull_low <= 1'h0;
    end
    else if (clk_en)
    begin
      fast_pull_low <= (next_state == ST_FAST); // R7
      full_pull_low <= (next_state == ST_FULL); // R11
      fault_pull_low <= (next_state == ST_FAULT); // R4 R9
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // No wait state: the answer is registered in the setup cycle so
  // that every bus output comes straight from a flip-flop.
  logic setup;
  logic take;
  logic mapped;
  logic [31:0] next_rdata;

  assign setup = apb_req.psel && !apb_req.penable && !apb_rsp.pready;
  assign take = apb_req.psel && apb_req.penable && apb_rsp.pready;

  always_comb
  begin
    mapped = 1'h1;
    next_rdata = '0;
    case (apb_req.paddr)
      CTRL_ADDR: next_rdata[CTRL_HALT_BIT] = soft_halt;
      STATUS_ADDR:
        next_rdata = {22'h00_0000, live.temp_ok, paused, fault_pull_low,
                      full_pull_low, fast_pull_low, charge_drive, state};
      TIMER_ONE_ADDR: next_rdata = {8'h00, phase_timer_one};
      TIMER_TWO_ADDR: next_rdata = {8'h00, phase_timer_two};
      default: mapped = 1'h0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      apb_rsp <= '0;
    else if (clk_en)
    begin
      apb_rsp.pready <= setup;
      apb_rsp.pslverr <= setup && !mapped;
      apb_rsp.prdata <= (setup && !apb_req.pwrite) ? next_rdata : '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      soft_halt <= CTRL_RESET;
    else if (clk_en && take && apb_req.pwrite &&
             apb_req.paddr == CTRL_ADDR)
      soft_halt <= apb_req.pwdata[CTRL_HALT_BIT];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_reset_dwell;
    clk_en && state == ST_RESET ##1 clk_en && state == ST_RESET;
  endsequence

  sequence s_prequal_timeout;
    clk_en && !halt && state == ST_PREQUAL && one_expired &&
    !live.above_uv && live.headroom_ok && !live.over_volt;
  endsequence

  property p_reset_clears;
    s_reset_dwell |-> phase_timer_one == '0 && phase_timer_two == '0 &&
      !fast_pull_low && !full_pull_low && !fault_pull_low;
  endproperty
  a_reset_clears: assert property (p_reset_clears) // R16
    else $error("timers or indicators not cleared in reset");
  property p_halt_forces_reset;
    clk_en && halt |=> state == ST_RESET && charge_drive == CUR_ZERO;
  endproperty
  a_halt_forces_reset: assert property (p_halt_forces_reset) // R19
    else $error("shutdown did not force reset");
  property p_prequal_drive;
    clk_en && next_state == ST_PREQUAL && live.temp_ok
      |=> state == ST_PREQUAL && charge_drive == CUR_TWENTIETH;
  endproperty
  a_prequal_drive: assert property (p_prequal_drive) // R2
    else $error("prequal current not one twentieth");
  property p_prequal_timeout;
    s_prequal_timeout |=> state == ST_FAULT && fault_pull_low;
  endproperty
  a_prequal_timeout: assert property (p_prequal_timeout) // R4
    else $error("prequal timeout did not fault");
  property p_pause_freezes;
    clk_en && paused && next_state == state
      |=> $stable(phase_timer_one) && $stable(phase_timer_two) &&
          charge_drive == CUR_ZERO;
  endproperty
  a_pause_freezes: assert property (p_pause_freezes) // R10
    else $error("pause did not freeze timers");
  property p_fast_timeout;
    clk_en && !halt && state == ST_FAST && two_expired &&
    !(live.temp_ok && live.at_reg_volt) && live.headroom_ok &&
    !live.over_volt |=> state == ST_FAULT ##0 !fast_pull_low;
  endproperty
  a_fast_timeout: assert property (p_fast_timeout) // R9
    else $error("fast timeout did not fault");
  property p_full_indicator;
    clk_en && state == ST_FAST && next_state == ST_FULL
      |=> full_pull_low && !fast_pull_low;
  endproperty
  a_full_indicator: assert property (p_full_indicator) // R11
    else $error("full indicator not pulled on entry");
  property p_fault_holds;
    clk_en && state == ST_FAULT && !halt |=> state == ST_FAULT;
  endproperty
  a_fault_holds: assert property (p_fault_holds) // R18
    else $error("fault left without shutdown");
  property p_done_zero;
    state == ST_DONE |-> charge_drive == CUR_ZERO;
  endproperty
  a_done_zero: assert property (p_done_zero) // R14
    else $error("current flows in done");

  property p_apb_answer;
    clk_en && setup |=> apb_rsp.pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer late");

endmodule

/* testbench/battery_pack_model.sv */
// Purpose: Battery, thermistor and supply model facing the sequencer.
// Assumes: The cell gains one voltage step per cycle of nonzero drive.
// Notes: Thresholds are scaled steps, not volts.

module battery_pack_model
  import charge_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire charge_seq_pkg::drive_t charge_drive,
  input wire logic drain,
  input wire logic stall,
  input wire logic taper_en,
  input wire logic run_pin,
  input wire logic temp_good,
  input wire logic headroom_good,
  input wire logic over_volt_in,
  output charge_seq_pkg::sense_t sense
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Cell state
  // ----------------------------------------------------------------
  int vbat = 0;
  int taper = 0;

  // A stalled cell stands for a dead battery that never lifts off.
  always @(posedge ref_clk)
  begin
    if (drain)
      vbat <= 0;
    else if (charge_drive != CUR_ZERO && !stall && vbat < 60)
      vbat <= vbat + 1;
    taper <= (charge_drive == CUR_CONST_V) ? taper + 1 : 0;
  end

  // ----------------------------------------------------------------
  // Comparator pins
  // ----------------------------------------------------------------
  always_comb
  begin
    sense.charger_off_input = run_pin;
    sense.bias_ok = 1'b1;
    sense.above_uv = vbat > 10;
    sense.temp_ok = temp_good;
    sense.at_reg_volt = vbat >= 50;
    sense.below_tenth = taper_en && taper >= 8;
    sense.below_recharge = vbat < 40;
    sense.headroom_ok = headroom_good;
    sense.over_volt = over_volt_in;
  end
endmodule

/* testbench/liion_charge_sequencer_bench.sv */
// Purpose: Self-checking bench for the charge sequencer.
// Assumes: Timer limits shrunk to 40, 80, 60 and 32 cycles.
// Notes: Status is read over APB and checked by a monitor queue.

module liion_charge_sequencer_bench
  import charge_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [31:0] m;
    logic [31:0] v;
    logic e;
  } note_t;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  drive_t charge_drive;
  logic fast_pull_low;
  logic full_pull_low;
  logic fault_pull_low;
  sense_t sense;
  logic drain = 1'b0;
  logic stall = 1'b0;
  logic taper_en = 1'b1;
  logic run_pin = 1'b0;
  logic temp_good = 1'b1;
  logic headroom_good = 1'b1;
  logic over_volt_in = 1'b0;
  logic [4:0] outs;
  note_t notes[$];
  note_t note;
  int bad_count = 0;
  int checked = 0;
  int seed = 32'h5cbc_f636;

  assign outs = {charge_drive, fast_pull_low, full_pull_low, fault_pull_low};

  always #12.5 ref_clk = ~ref_clk;

  charge_sequencer #(.TICK_LEN(4), .PREQUAL_TICKS(10), .FAST_TICKS(20),
    .FULL_TICKS(15), .TOPOFF_TICKS(8)) charge_sequencer_inst (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .sense(sense),
    .apb_req(req), .apb_rsp(rsp), .charge_drive(charge_drive),
    .fast_pull_low(fast_pull_low), .full_pull_low(full_pull_low),
    .fault_pull_low(fault_pull_low));

  battery_pack_model battery_pack_model_inst (
    .ref_clk(ref_clk), .charge_drive(charge_drive), .drain(drain),
    .stall(stall), .taper_en(taper_en), .run_pin(run_pin),
    .temp_good(temp_good), .headroom_good(headroom_good),
    .over_volt_in(over_volt_in), .sense(sense));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One edge passes first, so a released strobe never rises in one step.
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] m, input logic [31:0] v,
    input logic e);
    int n;
    @(posedge ref_clk);
    notes.push_back('{m, v, e});
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge ref_clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    chk({31'h0, rsp.pready}, 32'h1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rd_status(input charge_state_t s, input drive_t d,
    input logic [2:0] ind, input logic p);
    apb(1'b0, STATUS_ADDR, 32'h0, 32'h0000_03FF,
      {22'h0, temp_good, p, ind[0], ind[1], ind[2], d, s}, 1'b0);
  endtask

  task automatic wait_outs(input logic [4:0] w, input int lim);
    int n;
    n = 0;
    while (outs !== w && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk({27'h0, outs}, {27'h0, w});
  endtask

  task automatic pulse_drain();
    drain <= 1'b1;
    @(posedge ref_clk);
    drain <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (req.psel && req.penable && rsp.pready === 1'b1)
    begin
      if (notes.size() == 0)
        chk(32'h0, 32'h1);
      else
      begin
        note = notes.pop_front();
        chk(rsp.prdata & note.m, note.v);
        chk({31'h0, rsp.pslverr}, {31'h0, note.e});
      end
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    // The synchronised temperature bit needs two edges to show the pin.
    repeat (2) @(posedge ref_clk);
    rd_status(ST_RESET, CUR_ZERO, 3'b000, 1'b0);
    apb(1'b0, TIMER_ONE_ADDR, 32'h0, 32'h00FF_FFFF, 32'h0, 1'b0);
    apb(1'b0, TIMER_TWO_ADDR, 32'h0, 32'h00FF_FFFF, 32'h0, 1'b0);
    apb(1'b0, 12'h010 | (12'($random(seed)) & 12'hFF0), 32'h0,
      32'hFFFF_FFFF, 32'h0, 1'b1);
    for (int b = 1; b >= 0; b--)
    begin
      apb(1'b1, CTRL_ADDR, {31'($random(seed)), 1'(b)}, 32'h0, 32'h0, 1'b0);
      apb(1'b0, CTRL_ADDR, 32'h0, 32'h1, 32'(b), 1'b0);
    end
    run_pin <= 1'b1;
    wait_outs({CUR_TWENTIETH, 3'b000}, 20);
    rd_status(ST_PREQUAL, CUR_TWENTIETH, 3'b000, 1'b0);
    wait_outs({CUR_LIMIT, 3'b100}, 40);
    rd_status(ST_FAST, CUR_LIMIT, 3'b100, 1'b0);
    // The cell passes regulation voltage while frozen, so a running
    // sequencer would have left fast charge by the time of this check.
    clk_en <= 1'h0;
    repeat (40) @(posedge ref_clk);
    wait_outs({CUR_LIMIT, 3'b100}, 0);
    clk_en <= 1'h1;
    wait_outs({CUR_CONST_V, 3'b010}, 80);
    rd_status(ST_FULL, CUR_CONST_V, 3'b010, 1'b0);
    wait_outs({CUR_CONST_V, 3'b000}, 30);
    rd_status(ST_TOPOFF, CUR_CONST_V, 3'b000, 1'b0);
    wait_outs({CUR_ZERO, 3'b000}, 60);
    rd_status(ST_DONE, CUR_ZERO, 3'b000, 1'b0);
    taper_en <= 1'b0;
    pulse_drain();
    wait_outs({CUR_TWENTIETH, 3'b000}, 20);
    wait_outs({CUR_LIMIT, 3'b100}, 40);
    temp_good <= 1'b0;
    wait_outs({CUR_ZERO, 3'b100}, 10);
    rd_status(ST_FAST, CUR_ZERO, 3'b100, 1'b1);
    // The pause outlasts the fast limit, so a running timer would fault.
    repeat (100) @(posedge ref_clk);
    temp_good <= 1'b1;
    wait_outs({CUR_LIMIT, 3'b100}, 10);
    wait_outs({CUR_CONST_V, 3'b010}, 80);
    temp_good <= 1'b0;
    wait_outs({CUR_ZERO, 3'b010}, 10);
    rd_status(ST_FULL, CUR_ZERO, 3'b010, 1'b1);
    repeat (80) @(posedge ref_clk);
    temp_good <= 1'b1;
    wait_outs({CUR_CONST_V, 3'b010}, 10);
    wait_outs({CUR_CONST_V, 3'b000}, 80);
    wait_outs({CUR_ZERO, 3'b000}, 60);
    stall <= 1'b1;
    pulse_drain();
    wait_outs({CUR_TWENTIETH, 3'b000}, 20);
    temp_good <= 1'b0;
    wait_outs({CUR_ZERO, 3'b000}, 10);
    rd_status(ST_PREQUAL, CUR_ZERO, 3'b000, 1'b1);
    repeat (60) @(posedge ref_clk);
    temp_good <= 1'b1;
    wait_outs({CUR_TWENTIETH, 3'b000}, 10);
    wait_outs({CUR_ZERO, 3'b001}, 60);
    headroom_good <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rd_status(ST_FAULT, CUR_ZERO, 3'b001, 1'b0);
    headroom_good <= 1'b1;
    run_pin <= 1'b0;
    wait_outs({CUR_ZERO, 3'b000}, 10);
    rd_status(ST_RESET, CUR_ZERO, 3'b000, 1'b0);
    apb(1'b0, TIMER_ONE_ADDR, 32'h0, 32'h00FF_FFFF, 32'h0, 1'b0);
    stall <= 1'b0;
    run_pin <= 1'b1;
    wait_outs({CUR_LIMIT, 3'b100}, 60);
    stall <= 1'b1;
    wait_outs({CUR_ZERO, 3'b001}, 120);
    rd_status(ST_FAULT, CUR_ZERO, 3'b001, 1'b0);
    apb(1'b1, CTRL_ADDR, 32'h1, 32'h0, 32'h0, 1'b0);
    wait_outs({CUR_ZERO, 3'b000}, 10);
    rd_status(ST_RESET, CUR_ZERO, 3'b000, 1'b0);
    apb(1'b1, CTRL_ADDR, 32'h0, 32'h0, 32'h0, 1'b0);
    wait_outs({CUR_LIMIT, 3'b100}, 20);
    headroom_good <= 1'b0;
    wait_outs({CUR_ZERO, 3'b000}, 10);
    rd_status(ST_RESET, CUR_ZERO, 3'b000, 1'b0);
    headroom_good <= 1'b1;
    wait_outs({CUR_LIMIT, 3'b100}, 20);
    over_volt_in <= 1'b1;
    wait_outs({CUR_ZERO, 3'b000}, 10);
    rd_status(ST_RESET, CUR_ZERO, 3'b000, 1'b0);
    report_and_stop();
  end

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end
endmodule
